// ### dsc_pkg.sv
// Package for the strobe-timing DRAM controller: timing figures, cycle counts, carriers.
// Assumes a 10 MHz reference clock (100 ns period).
package dsc_pkg;
   localparam int CLK_PERIOD_NS   = 100;
   // Timing limits in ns (refresh period in ms), fastest grade; rounded up to whole clocks, at least one
   localparam int T_RC_NS         = 320;
   localparam int T_PC_NS         = 160;
   localparam int T_RCD_MIN_NS    = 25;
   localparam int T_RCD_MAX_NS    = 40;
   localparam int T_RAH_NS        = 15;
   localparam int T_CAH_NS        = 40;
   localparam int T_WCH_NS        = 40;
   localparam int T_WP_NS         = 40;
   localparam int T_RWL_NS        = 60;
   localparam int T_CWL_NS        = 60;
   localparam int T_RP_NS         = 80;
   localparam int T_RAS_NS        = 120;
   localparam int T_CAS_NS        = 80;
   localparam int T_CAC_NS        = 80;
   localparam int T_RAC_NS        = 120;
   localparam int T_CWD_NS        = 60;
   localparam int T_RWD_NS        = 100;
   localparam int T_OFF_NS        = 35;
   localparam int T_REF_MS        = 4;
   localparam int REFRESH_ROWS    = 256;
   localparam int POWERUP_CYCLES  = 8;

   function automatic int ns_to_clk(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int CYC_RCD       = ns_to_clk(T_RCD_MIN_NS);
   localparam int CYC_RAH       = ns_to_clk(T_RAH_NS);
   localparam int CYC_CAS_LOW   = ns_to_clk(T_CAS_NS) > ns_to_clk(T_CAC_NS) ?
                                  ns_to_clk(T_CAS_NS) : ns_to_clk(T_CAC_NS);
   localparam int CYC_WE_LEAD   = ns_to_clk(T_CWL_NS) > ns_to_clk(T_WCH_NS) ?
                                  ns_to_clk(T_CWL_NS) : ns_to_clk(T_WCH_NS);
   localparam int CYC_RP        = ns_to_clk(T_RP_NS);
   localparam int CYC_RAS       = ns_to_clk(T_RAS_NS);
   localparam int CYC_RC        = ns_to_clk(T_RC_NS);
   localparam int CYC_PC        = ns_to_clk(T_PC_NS);
   localparam int CYC_OFF       = ns_to_clk(T_OFF_NS);
   // 4 ms over 256 rows gives 15.625 us per row; rounded down
   localparam int CYC_REF_ROW   = (T_REF_MS * 1000000) / (REFRESH_ROWS * CLK_PERIOD_NS);
   localparam int CNT_W         = 8;
   localparam logic [7:0] ROW_RESET = 8'h00;

   typedef struct packed {
      logic        write;
      logic [15:0] addr;
      logic        data;
   } dsc_req_type;

   typedef struct packed {
      logic       ras_n;
      logic       cas_n;
      logic       we_n;
      logic [7:0] mux_address;
      logic       din;
   } dsc_pins_type;
endpackage

// ### dsc_timer.sv
// Down-counter used to space strobe edges.
// Assumes load and count values fit CNT_W bits.
`timescale 1ns/10ps
module dsc_timer
   import dsc_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] value,
   output logic                  done
);
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;

   always_comb begin
      next_count = count;
      if (load) begin
         next_count = value;
      end else if (count != '0) begin
         next_count = count - 8'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   // Done from the registered count alone, so a caller may gate load on it with no loop
   assign done = (count == '0);
endmodule

// ### dsc_controller.sv
// Host-side controller for a 64K x 1 multiplexed-address dynamic RAM.
// Assumes one request at a time, inputs synchronous to ref_clk, 100 ns clock.
`timescale 1ns/10ps
module dsc_controller
   import dsc_pkg::*;
#(
   parameter int REF_PERIOD = dsc_pkg::CYC_REF_ROW
)
(
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire dsc_pkg::dsc_req_type req,
   input  wire logic               req_valid,
   output logic                    req_ready,
   output logic                    rd_valid,
   output logic                    rd_data,
   output logic                    init_done,
   output dsc_pkg::dsc_pins_type   pins,
   input  wire logic               dout,
   input  wire logic               dout_valid
);
   import dsc_pkg::*;

   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_RAS   = 8'h02,
      ST_COL   = 8'h04,
      ST_CAS   = 8'h08,
      ST_PRE   = 8'h10,
      ST_REF   = 8'h20,
      ST_REFPR = 8'h40,
      ST_GAP   = 8'h80
   } dsc_state_type;

   dsc_state_type    state;
   dsc_state_type    next_state;
   dsc_req_type      hold;
   dsc_req_type      next_hold;
   dsc_pins_type     next_pins;
   logic [3:0]       init_cnt;
   logic [3:0]       next_init_cnt;
   logic [7:0]       row;
   logic [7:0]       next_row;
   logic [15:0]      ref_cnt;
   logic [15:0]      next_ref_cnt;
   logic             ref_due;
   logic             next_ref_due;
   logic             next_rd_valid;
   logic             next_rd_data;
   logic             tload;
   logic [CNT_W-1:0] tval;
   logic             tdone;
   logic             rc_load;
   logic             rc_done;

   // Phase timer and row-cycle spacing timer
   dsc_timer u_phase (
      .ref_clk (ref_clk),
      .rst     (rst),
      .load    (tload),
      .value   (tval),
      .done    (tdone)
   );

   dsc_timer u_rc (
      .ref_clk (ref_clk),
      .rst     (rst),
      .load    (rc_load),
      .value   (CNT_W'(CYC_RC - 1)),
      .done    (rc_done)
   );

   assign init_done = (init_cnt == 4'(POWERUP_CYCLES));
   assign req_ready = (state == ST_IDLE) && init_done && !ref_due && rc_done;

   // Refresh pacing
   always_comb begin
      next_ref_cnt = ref_cnt + 16'h0001;
      next_ref_due = ref_due;
      if (ref_cnt >= 16'(REF_PERIOD - 1)) begin
         next_ref_cnt = 16'h0000;
         next_ref_due = 1'b1;
      end
      if (state == ST_REFPR && tdone && init_done) begin
         next_ref_due = 1'b0;
         if (ref_cnt >= 16'(REF_PERIOD - 1)) begin
            next_ref_due = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ref_cnt <= 16'h0000;
         ref_due <= 1'b0;
      end else begin
         ref_cnt <= next_ref_cnt;
         ref_due <= next_ref_due;
      end
   end

   // Main cycle sequencer
   always_comb begin
      next_state    = state;
      next_hold     = hold;
      next_pins     = pins;
      next_init_cnt = init_cnt;
      next_row      = row;
      next_rd_valid = 1'b0;
      next_rd_data  = rd_data;
      tload         = 1'b0;
      tval          = '0;
      rc_load       = 1'b0;
      unique case (state)
         ST_IDLE: begin
            next_pins.ras_n = 1'b1;
            next_pins.cas_n = 1'b1;
            next_pins.we_n  = 1'b1;
            if (rc_done && (!init_done || ref_due)) begin
               next_pins.mux_address = row;
               next_state = ST_REF;
            end else if (req_ready && req_valid) begin
               next_hold = req;
               next_pins.mux_address = req.addr[15:8];
               next_pins.din = req.data;
               next_state = ST_RAS;
            end
         end
         ST_REF: begin
            // row-only cycle, column strobe stays high
            next_pins.ras_n = 1'b0;
            rc_load = 1'b1;
            tload = 1'b1;
            tval = CNT_W'(CYC_RAS - 1);
            next_state = ST_REFPR;
         end
         ST_REFPR: begin
            if (tdone) begin
               if (!pins.ras_n) begin
                  next_pins.ras_n = 1'b1;
                  tload = 1'b1;
                  tval = CNT_W'(CYC_RP - 1);
               end else begin
                  next_row = row + 8'h01;
                  if (!init_done) begin
                     next_init_cnt = init_cnt + 4'h1;
                  end
                  next_state = ST_IDLE;
               end
            end
         end
         ST_RAS: begin
            next_pins.ras_n = 1'b0;
            rc_load = 1'b1;
            tload = 1'b1;
            tval = CNT_W'((CYC_RAH > CYC_RCD ? CYC_RAH : CYC_RCD) - 1);
            next_state = ST_COL;
         end
         ST_COL: begin
            if (tdone) begin
               next_pins.mux_address = hold.addr[7:0];
               // early write only, else enable stays high
               next_pins.we_n = !hold.write;
               next_state = ST_CAS;
               tload = 1'b1;
               tval = 8'h00;
            end
         end
         ST_CAS: begin
            if (pins.cas_n && tdone) begin
               next_pins.cas_n = 1'b0;
               tload = 1'b1;
               tval = CNT_W'((CYC_CAS_LOW > CYC_WE_LEAD ? CYC_CAS_LOW : CYC_WE_LEAD) +
                             (CYC_RAS > CYC_RCD + CYC_CAS_LOW ?
                              CYC_RAS - CYC_RCD - CYC_CAS_LOW : 0) - 1);
            end else if (!pins.cas_n && tdone) begin
               if (!hold.write) begin
                  next_rd_valid = 1'b1;
                  next_rd_data  = dout_valid ? dout : 1'b0;
               end
               next_pins.cas_n = 1'b1;
               next_pins.ras_n = 1'b1;
               next_pins.we_n  = 1'b1;
               tload = 1'b1;
               tval = CNT_W'((CYC_RP > CYC_OFF ? CYC_RP : CYC_OFF) - 1);
               next_state = ST_PRE;
            end
         end
         ST_PRE: begin
            if (tdone) begin
               next_state = ST_GAP;
            end
         end
         ST_GAP: begin
            // page spacing is implied: each access is a full row cycle
            next_state = (CYC_PC > 0) ? ST_IDLE : ST_GAP;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state    <= ST_IDLE;
         hold     <= '0;
         pins     <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, mux_address: 8'h00, din: 1'b0};
         init_cnt <= 4'h0;
         row      <= ROW_RESET;
         rd_valid <= 1'b0;
         rd_data  <= 1'b0;
      end else begin
         state    <= next_state;
         hold     <= next_hold;
         pins     <= next_pins;
         init_cnt <= next_init_cnt;
         row      <= next_row;
         rd_valid <= next_rd_valid;
         rd_data  <= next_rd_data;
      end
   end
   // late-write cycles not used; trades speed for a shared data bus
   // figures live in the package for grade substitution
endmodule

// ### dsc_ctrl_props.sv
// Checker of strobe order and spacing at the controller's pins.
// Assumes it is bound onto dsc_controller; one clock domain.
`timescale 1ns/10ps
module dsc_ctrl_props
   import dsc_pkg::*;
#(
   parameter int REF_PERIOD = 156
)
(
   input wire logic         ref_clk,
   input wire logic         rst,
   input wire dsc_req_type  req,
   input wire logic         req_valid,
   input wire logic         req_ready,
   input wire logic         rd_valid,
   input wire logic         rd_data,
   input wire logic         init_done,
   input wire dsc_pins_type pins,
   input wire logic         dout,
   input wire logic         dout_valid
);
   int gap;
   int next_gap;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Cycles since the row strobe was last low
   always_comb next_gap = (!pins.ras_n) ? 0 : gap + 1;
   always_ff @(posedge ref_clk) gap <= rst ? 0 : next_gap;
   sequence s_cas_fall; $fell(pins.cas_n); endsequence
   sequence s_ras_fall; $fell(pins.ras_n); endsequence
   a_cas_after_ras: assert property (s_cas_fall |-> !pins.ras_n && !$past(pins.ras_n))
      else $error("column strobe too soon after row strobe");
   a_cas_high_ras: assert property (s_ras_fall |-> pins.cas_n)
      else $error("column strobe low at row strobe fall");
   a_row_addr_hold: assert property (s_ras_fall |-> $stable(pins.mux_address))
      else $error("row address not held");
   a_col_addr_hold: assert property (s_cas_fall |-> $stable(pins.mux_address)[*2])
      else $error("column address not held");
   a_ras_spacing: assert property (s_ras_fall |=> (!$fell(pins.ras_n))[*3])
      else $error("row strobe falls too close");
   a_early_write: assert property ((s_cas_fall and !pins.we_n) |-> !$past(pins.we_n))
      else $error("write enable not set before column strobe");
   a_read_we_high: assert property ((s_cas_fall and pins.we_n) |-> $past(pins.we_n))
      else $error("write enable not high before read");
   a_write_hold: assert property ((s_cas_fall and !$past(pins.we_n)) |-> !pins.we_n)
      else $error("write enable released too soon");
   a_we_width: assert property ($fell(pins.we_n) |=> !pins.we_n)
      else $error("write enable pulse too short");
   a_we_ras_lead: assert property ($rose(pins.ras_n) && !$past(pins.we_n) |-> !$past(pins.we_n, 2))
      else $error("write enable late before row strobe rise");
   a_we_cas_lead: assert property ($rose(pins.cas_n) && !$past(pins.we_n) |-> !$past(pins.we_n, 2))
      else $error("write enable late before column strobe rise");
   a_read_answer: assert property ((s_cas_fall and pins.we_n) |-> ##1 rd_valid)
      else $error("read answer not on time");
   a_init_gate: assert property (!init_done |-> !req_ready)
      else $error("request accepted before power-up refresh");
   // Margin of 16 allows one access to delay a pending refresh
   a_refresh_due: assert property (init_done |-> gap <= REF_PERIOD + 16)
      else $error("refresh overdue");
endmodule
bind dsc_controller dsc_ctrl_props #(.REF_PERIOD(REF_PERIOD)) i_props (.ref_clk(ref_clk),
   .rst(rst), .req(req), .req_valid(req_valid), .req_ready(req_ready), .rd_valid(rd_valid),
   .rd_data(rd_data), .init_done(init_done), .pins(pins), .dout(dout), .dout_valid(dout_valid));

// ### dsc_dram_model.sv
// Behavioural 64K x 1 dynamic RAM answering on the controller's pins.
// Assumes pins change only at clock edges; the device has no clock.
`timescale 1ns/10ps
module dsc_dram_model
   import dsc_pkg::*;
#(
   parameter int ACC_NS = 70
)
(
   input  wire dsc_pkg::dsc_pins_type pins,
   output logic                       dout,
   output logic                       dout_valid
);
   logic       mem [0:65535];
   logic [7:0] row = 8'h00;
   logic [7:0] col = 8'h00;
   initial dout = 1'b0;
   initial dout_valid = 1'b0;
   always @(negedge pins.ras_n) row = pins.mux_address;
   always @(negedge pins.cas_n) begin
      col = pins.mux_address;
      if (!pins.ras_n && !pins.we_n) begin
         mem[{row, col}] = pins.din;
      end else if (!pins.ras_n) begin
         // Slow answer, still inside the access limit
         #(ACC_NS);
         if (!pins.cas_n) begin
            dout = mem[{row, col}];
            dout_valid = 1'b1;
         end
      end
   end
   always @(negedge pins.we_n) begin
      if (!pins.ras_n && !pins.cas_n) mem[{row, col}] = pins.din;
   end
   // Released line shows the inverse, not a stale value
   always @(posedge pins.cas_n) begin
      #(T_OFF_NS);
      dout_valid = 1'b0;
      dout = ~dout;
   end
endmodule

// ### tb_top.sv
// Testbench: controller against a behavioural one-bit DRAM model.
// Assumes a short refresh period to keep the run brief.
`timescale 1ns/10ps
module tb_top;
   import dsc_pkg::*;
   localparam int REF_P = 20;
   logic         ref_clk = 1'b0;
   logic         rst = 1'b1;
   dsc_req_type  req = '0;
   logic         req_valid = 1'b0;
   logic         req_ready, rd_valid, rd_data, init_done, dout, dout_valid;
   dsc_pins_type pins;
   int           mismatches = 0;
   int           compares = 0;
   int           ras_cnt = 0;
   int           cas_cnt = 0;
   time          last_ras = 0;
   time          min_gap = 1000000;
   always #50 ref_clk = ~ref_clk;
   dsc_controller #(.REF_PERIOD(REF_P)) i_dut (.ref_clk(ref_clk), .rst(rst), .req(req),
      .req_valid(req_valid), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
      .init_done(init_done), .pins(pins), .dout(dout), .dout_valid(dout_valid));
   dsc_dram_model #(.ACC_NS(70)) i_mem (.pins(pins), .dout(dout), .dout_valid(dout_valid));
   always @(negedge pins.ras_n) begin
      ras_cnt++;
      if (ras_cnt > 1 && $time - last_ras < min_gap) min_gap = $time - last_ras;
      last_ras = $time;
   end
   always @(negedge pins.cas_n) cas_cnt++;
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic do_req(input logic w, input logic [15:0] a, input logic d);
      int n;
      n = 0;
      @(posedge ref_clk);
      req <= '{write: w, addr: a, data: d};
      req_valid <= 1'b1;
      @(negedge ref_clk);
      while (req_ready !== 1'b1 && n < 400) begin
         @(negedge ref_clk);
         n++;
      end
      check("request taken", 32'h1, {31'h0, req_ready});
      @(posedge ref_clk);
      req_valid <= 1'b0;
      if (w == 1'b0) begin
         n = 0;
         @(negedge ref_clk);
         while (rd_valid !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
         end
         check("read answer", 32'h1, {31'h0, rd_valid});
         check("read data", {31'h0, d}, {31'h0, rd_data});
      end
   endtask
   task automatic t_init();
      int n;
      int r0;
      int c0;
      n = 0;
      r0 = ras_cnt;
      c0 = cas_cnt;
      while (init_done !== 1'b1 && n < 2000) begin
         @(negedge ref_clk);
         n++;
      end
      check("power-up refreshes", 32'h1, {31'h0, ras_cnt - r0 >= 8});
      check("column strobes at power-up", c0, cas_cnt);
   endtask
   task automatic t_rw();
      logic [15:0] a [4];
      logic        d [4];
      a = '{16'h0000, 16'hFFFF, 16'h00FF, 16'hFF00};
      d = '{1'b1, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 4; i++) do_req(1'b1, a[i], d[i]);
      for (int i = 0; i < 4; i++) do_req(1'b0, a[i], d[i]);
      do_req(1'b1, 16'h00FF, 1'b0);
      do_req(1'b0, 16'h00FF, 1'b0);
   endtask
   task automatic t_refresh();
      int r0;
      int c0;
      r0 = ras_cnt;
      c0 = cas_cnt;
      repeat (10 * REF_P) @(posedge ref_clk);
      check("idle refreshes", 32'h1, {31'h0, ras_cnt - r0 >= 9});
      check("idle column strobes", c0, cas_cnt);
      check("row strobe spacing", 32'h1, {31'h0, min_gap >= 320});
   endtask
   task automatic t_reset_mid();
      int r0;
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      check("row strobe after reset", 32'h1, {31'h0, pins.ras_n});
      check("ready after reset", 32'h0, {31'h0, req_ready});
      r0 = ras_cnt;
      t_init();
      check("second power-up refreshes", 32'h1, {31'h0, ras_cnt - r0 >= 8});
      do_req(1'b0, 16'h0000, 1'b1);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #(50000 * 100);
      mismatches++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      t_init();
      t_rw();
      t_refresh();
      t_reset_mid();
      report_and_stop();
   end
endmodule
